// ---- design/scci_map.vh ----
// constants of the serial configuration command interpreter
// assumes a byte-wide receive stream and byte-wide transmit stream
`ifndef SCCI_MAP_VH
`define SCCI_MAP_VH
`define SCCI_CLK_HZ            25000000
`define SCCI_B_SILENCE_AFTER   8'h05
`define SCCI_B_SILENCE_BEFORE  8'h04
`define SCCI_B_UART_RATE       8'h15
`define SCCI_B_ESCAPE_CHAR     8'h13
`define SCCI_B_EXIT_CMD        8'h09
`define SCCI_B_RETRY           8'h18
`define SCCI_B_STOP_BIT        8'h36
`define SCCI_B_SLEEP_SEL       8'h01
`define SCCI_B_IDLE_SLEEP      8'h02
`define SCCI_B_SER_UPPER       8'h25
`define SCCI_B_SER_LOWER       8'h26
`define SCCI_B_STREAM_LIM      8'h1a
`define SCCI_B_FW_VER          8'h14
`define SCCI_B_SRC_ADDR        8'h2a
`define SCCI_B_AUTO_ADDR       8'h3a
`define SCCI_RST_SILENCE       16'h000a
`define SCCI_RST_RATE          16'h0003
`define SCCI_RST_ESCAPE        16'h002b
`define SCCI_RST_RETRY         16'h0000
`define SCCI_RST_STOP          16'h0000
`define SCCI_RST_SLEEP         16'h0000
`define SCCI_RST_IDLE          16'h0064
`define SCCI_RST_STREAM        16'hffff
`define SCCI_RST_SRC           16'hffff
`define SCCI_MIN_SILENCE       16'h0002
`define SCCI_MIN_IDLE          16'h0010
`define SCCI_MIN_NONSTD        16'h007d
`define SCCI_MAX_STD           16'h0006
`define SCCI_UNIT_MS           100
`define SCCI_OVERSAMPLE        16
`endif

// ---- design/scci_top.v ----
// serial configuration command interpreter: text and binary parameter commands
// assumes bytes arrive already deserialised, one per i_RX_VALID pulse
`timescale 1ns/10ps
`include "scci_map.vh"

module scci_top #(
    parameter [15:0] FW_VERSION = 16'h1234, // arbitrary value
    parameter        ENHANCED   = 1'b1
) (
    input  wire        I_SYS_CLK,
    input  wire        I_ARST_N,
    input  wire        i_RX_VALID,
    input  wire [7:0]  i_RX_DATA,
    input  wire        i_BIN_MODE,
    input  wire [31:0] i_SERIAL_NUMBER,
    output reg         o_TX_VALID,
    output reg  [7:0]  o_TX_DATA,
    output reg         o_CMD_ERROR,
    output reg         o_CMD_DONE,
    output reg         o_EXIT_CMD_MODE,
    output reg  [15:0] o_UART_DIVISOR,
    output reg  [15:0] o_SOURCE_ADDRESS,
    output reg  [15:0] o_SILENCE_BEFORE_ESCAPE,
    output reg  [15:0] o_SILENCE_AFTER_ESCAPE,
    output reg  [7:0]  o_ESCAPE_CHARACTER,
    output reg  [7:0]  o_RETRY_COUNT,
    output reg         o_STOP_BIT_SETTING,
    output reg  [3:0]  o_SLEEP_SELECT,
    output reg  [15:0] o_IDLE_BEFORE_SLEEP,
    output reg  [15:0] o_STREAMING_LIMIT,
    output reg  [15:0] o_UART_RATE_SETTING
);

    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_TXT  = 5'h02;
    localparam [4:0] ST_BIN  = 5'h04;
    localparam [4:0] ST_EXEC = 5'h08;
    localparam [4:0] ST_RESP = 5'h10;
    localparam [31:0] BASE_DIV = `SCCI_CLK_HZ / `SCCI_OVERSAMPLE;
    localparam [31:0] DEF_DIV  = BASE_DIV / 32'd9600;

    reg  [4:0]  state;
    reg  [7:0]  code;
    reg  [15:0] value;
    reg  [2:0]  ndig;
    reg         have_val;
    reg         text_mode;
    reg  [1:0]  bcnt;
    reg  [15:0] resp;
    reg  [1:0]  resp_left;
    reg  [1:0]  tch;
    reg  [7:0]  first_ch;
    reg  [15:0] pending_div;
    reg  [4:0]  hex_nib;
    reg  [7:0]  map_code;
    reg  [15:0] cur_val;
    reg  [1:0]  ret_bytes;
    reg         ok;
    reg  [31:0] div_calc;
    reg  [15:0] next_div;
    reg  [15:0] next_stored;

    // hex digit decode, bit 4 flags a non-digit
    always @* begin
        if (i_RX_DATA >= 8'h30 && i_RX_DATA <= 8'h39)
            hex_nib = {1'b0, i_RX_DATA[3:0]};
        else if ((i_RX_DATA >= 8'h41 && i_RX_DATA <= 8'h46) ||
                 (i_RX_DATA >= 8'h61 && i_RX_DATA <= 8'h66))
            hex_nib = {1'b0, i_RX_DATA[3:0] + 4'h9};
        else
            hex_nib = 5'h10;
    end

    // text names mapped onto binary codes, 8'hff unknown
    always @* begin
        case ({first_ch, i_RX_DATA})
            "AT": map_code = `SCCI_B_SILENCE_AFTER;
            "BT": map_code = `SCCI_B_SILENCE_BEFORE;
            "BD": map_code = `SCCI_B_UART_RATE;
            "CC": map_code = `SCCI_B_ESCAPE_CHAR;
            "CN": map_code = `SCCI_B_EXIT_CMD;
            "RR": map_code = `SCCI_B_RETRY;
            "SB": map_code = `SCCI_B_STOP_BIT;
            "SM": map_code = `SCCI_B_SLEEP_SEL;
            "ST": map_code = `SCCI_B_IDLE_SLEEP;
            "SH": map_code = `SCCI_B_SER_UPPER;
            "SL": map_code = `SCCI_B_SER_LOWER;
            "TT": map_code = `SCCI_B_STREAM_LIM;
            "VR": map_code = `SCCI_B_FW_VER;
            "MY": map_code = `SCCI_B_SRC_ADDR;
            "AM": map_code = `SCCI_B_AUTO_ADDR;
            default: map_code = 8'hff;
        endcase
    end

    // divisor and stored value for a rate request
    always @* begin
        div_calc = 32'h0;
        next_div = 16'h0;
        next_stored = value;
        if (value <= `SCCI_MAX_STD) begin
            if (value == 16'h0006)
                div_calc = BASE_DIV / 32'd57600;
            else
                div_calc = BASE_DIV / (32'd1200 << value[2:0]);
            next_div = div_calc[15:0];
            next_stored = value;
        end else begin
            // rounding divide gives the nearest reachable rate
            div_calc = (BASE_DIV + {16'h0, value[15:1]}) / {16'h0, value};
            if (div_calc == 32'h0)
                div_calc = 32'h1;
            next_div = div_calc[15:0];
            div_calc = (BASE_DIV + {16'h0, 1'b0, next_div[15:1]}) / {16'h0, next_div};
            next_stored = div_calc[15:0];
        end
    end

    // current value and length of answer, plus validity
    always @* begin
        cur_val = 16'h0;
        ret_bytes = 2'd2;
        ok = 1'b1;
        case (code)
            `SCCI_B_SILENCE_AFTER: begin
                cur_val = o_SILENCE_AFTER_ESCAPE;
                ok = !have_val || value >= `SCCI_MIN_SILENCE;
            end
            `SCCI_B_SILENCE_BEFORE: begin
                cur_val = o_SILENCE_BEFORE_ESCAPE;
                ok = !have_val || value >= `SCCI_MIN_SILENCE;
            end
            `SCCI_B_UART_RATE: begin
                cur_val = o_UART_RATE_SETTING;
                ok = !have_val || value <= `SCCI_MAX_STD || value >= `SCCI_MIN_NONSTD;
            end
            `SCCI_B_ESCAPE_CHAR: begin
                cur_val = {8'h0, o_ESCAPE_CHARACTER};
                ret_bytes = 2'd1;
                ok = !have_val || (value >= 16'h0020 && value <= 16'h007f);
            end
            `SCCI_B_RETRY: begin
                cur_val = {8'h0, o_RETRY_COUNT};
                ret_bytes = 2'd1;
                ok = !have_val || value <= 16'h00ff;
            end
            `SCCI_B_STOP_BIT: begin
                cur_val = {15'h0, o_STOP_BIT_SETTING};
                ret_bytes = 2'd1;
                ok = !have_val || value <= 16'h0001;
            end
            `SCCI_B_SLEEP_SEL: begin
                cur_val = {12'h0, o_SLEEP_SELECT};
                ret_bytes = 2'd1;
                // value two is not a legal mode
                ok = !have_val || (value <= 16'h0008 && value != 16'h0002);
            end
            `SCCI_B_IDLE_SLEEP: begin
                cur_val = o_IDLE_BEFORE_SLEEP;
                ok = !have_val || value >= `SCCI_MIN_IDLE;
            end
            `SCCI_B_SER_UPPER: cur_val = i_SERIAL_NUMBER[31:16];
            `SCCI_B_SER_LOWER: cur_val = i_SERIAL_NUMBER[15:0];
            `SCCI_B_STREAM_LIM: cur_val = o_STREAMING_LIMIT;
            `SCCI_B_FW_VER: cur_val = FW_VERSION;
            `SCCI_B_SRC_ADDR: begin
                cur_val = o_SOURCE_ADDRESS;
                ok = ENHANCED;
            end
            `SCCI_B_AUTO_ADDR: begin
                ret_bytes = 2'd0;
                ok = ENHANCED;
            end
            `SCCI_B_EXIT_CMD: ret_bytes = 2'd0;
            default: begin
                ok = 1'b0;
                ret_bytes = 2'd0;
            end
        endcase
    end

    always @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            state <= ST_IDLE;
            code <= 8'h00;
            value <= 16'h0000;
            ndig <= 3'd0;
            have_val <= 1'b0;
            text_mode <= 1'b0;
            bcnt <= 2'd0;
            resp <= 16'h0000;
            resp_left <= 2'd0;
            tch <= 2'd0;
            first_ch <= 8'h00;
            pending_div <= 16'h0;
            o_TX_VALID <= 1'b0;
            o_TX_DATA <= 8'h00;
            o_CMD_ERROR <= 1'b0;
            o_CMD_DONE <= 1'b0;
            o_EXIT_CMD_MODE <= 1'b0;
            o_UART_DIVISOR <= 16'h0;
            o_SOURCE_ADDRESS <= `SCCI_RST_SRC;
            o_SILENCE_BEFORE_ESCAPE <= `SCCI_RST_SILENCE;
            o_SILENCE_AFTER_ESCAPE <= `SCCI_RST_SILENCE;
            o_ESCAPE_CHARACTER <= 8'h2b;
            o_RETRY_COUNT <= 8'h00;
            o_STOP_BIT_SETTING <= 1'b0;
            o_SLEEP_SELECT <= 4'h0;
            o_IDLE_BEFORE_SLEEP <= `SCCI_RST_IDLE;
            o_STREAMING_LIMIT <= `SCCI_RST_STREAM;
            o_UART_RATE_SETTING <= `SCCI_RST_RATE;
        end else begin
            o_TX_VALID <= 1'b0;
            o_CMD_ERROR <= 1'b0;
            o_CMD_DONE <= 1'b0;
            o_EXIT_CMD_MODE <= 1'b0;
            // divisor starts from the default rate after reset release
            if (o_UART_DIVISOR == 16'h0)
                o_UART_DIVISOR <= DEF_DIV[15:0];
            case (state)
                ST_IDLE: begin
                    value <= 16'h0;
                    ndig <= 3'd0;
                    have_val <= 1'b0;
                    bcnt <= 2'd0;
                    tch <= 2'd0;
                    if (i_RX_VALID && i_BIN_MODE) begin
                        code <= i_RX_DATA;
                        text_mode <= 1'b0;
                        state <= ST_BIN;
                    end else if (i_RX_VALID) begin
                        first_ch <= i_RX_DATA;
                        text_mode <= 1'b1;
                        tch <= 2'd1;
                        state <= ST_TXT;
                    end
                end
                ST_TXT: if (i_RX_VALID) begin
                    if (tch == 2'd1) begin
                        code <= map_code;
                        tch <= 2'd2;
                    end else if (i_RX_DATA == 8'h0d) begin
                        state <= ST_EXEC;
                    end else if (i_RX_DATA == 8'h20) begin
                        state <= ST_TXT;
                    end else if (hex_nib[4] || ndig == 3'd4) begin
                        code <= 8'hff;
                    end else begin
                        value <= {value[11:0], hex_nib[3:0]};
                        ndig <= ndig + 3'd1;
                        have_val <= 1'b1;
                    end
                end
                ST_BIN: begin
                    if (!i_BIN_MODE) begin
                        state <= ST_EXEC;
                    end else if (i_RX_VALID) begin
                        // low byte first, then high byte
                        if (bcnt == 2'd0)
                            value[7:0] <= i_RX_DATA;
                        else
                            value[15:8] <= i_RX_DATA;
                        bcnt <= bcnt + 2'd1;
                        have_val <= 1'b1;
                        if (bcnt == 2'd1)
                            state <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    state <= ST_IDLE;
                    if (!ok) begin
                        o_CMD_ERROR <= 1'b1;
                    end else begin
                        o_CMD_DONE <= 1'b1;
                        if (!have_val && ret_bytes != 2'd0 && text_mode) begin
                            // one-byte values moved up so both lengths shift from the top
                            resp <= (ret_bytes == 2'd1) ? {cur_val[7:0], 8'h00} : cur_val;
                            resp_left <= ret_bytes;
                            state <= ST_RESP;
                        end
                        case (code)
                            `SCCI_B_EXIT_CMD: begin
                                if (pending_div != 16'h0)
                                    o_UART_DIVISOR <= pending_div;
                                o_EXIT_CMD_MODE <= 1'b1;
                            end
                            `SCCI_B_AUTO_ADDR: begin
                                o_SOURCE_ADDRESS <= {i_SERIAL_NUMBER[29:28],
                                                     i_SERIAL_NUMBER[13:0]};
                            end
                            default: ;
                        endcase
                        if (have_val) begin
                            case (code)
                                `SCCI_B_SILENCE_AFTER: o_SILENCE_AFTER_ESCAPE <= value;
                                `SCCI_B_SILENCE_BEFORE: o_SILENCE_BEFORE_ESCAPE <= value;
                                `SCCI_B_UART_RATE: begin
                                    // divisor held in pending_div until exit; rate setting stored now
                                    pending_div <= next_div;
                                    o_UART_RATE_SETTING <= next_stored;
                                end
                                `SCCI_B_ESCAPE_CHAR: o_ESCAPE_CHARACTER <= value[7:0];
                                `SCCI_B_RETRY: o_RETRY_COUNT <= value[7:0];
                                `SCCI_B_STOP_BIT: o_STOP_BIT_SETTING <= value[0];
                                `SCCI_B_SLEEP_SEL: o_SLEEP_SELECT <= value[3:0];
                                `SCCI_B_IDLE_SLEEP: o_IDLE_BEFORE_SLEEP <= value;
                                `SCCI_B_STREAM_LIM: o_STREAMING_LIMIT <= value;
                                `SCCI_B_SRC_ADDR: o_SOURCE_ADDRESS <= value;
                                default: ;
                            endcase
                        end
                    end
                end
                ST_RESP: begin
                    // one hex nibble per cycle, most significant first
                    o_TX_VALID <= 1'b1;
                    if (resp_left == 2'd0) begin
                        o_TX_DATA <= 8'h0d;
                        state <= ST_IDLE;
                    end else begin
                        o_TX_DATA <= (resp[15:12] < 4'ha) ? {4'h3, resp[15:12]}
                                                          : {4'h4, resp[15:12] - 4'h9};
                        resp <= {resp[11:0], 4'h0};
                        ndig <= ndig + 3'd1;
                        // two nibbles make one byte of the answer
                        if (ndig[0])
                            resp_left <= resp_left - 2'd1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

endmodule // scci_top

// ---- tb/scci_checker.sv ----
// checker of the command interpreter outputs
// assumes it is bound to scci_top and sees one clock domain
`timescale 1ns/10ps
module scci_checker (
    input wire        I_SYS_CLK,
    input wire        I_ARST_N,
    input wire        o_CMD_ERROR,
    input wire        o_CMD_DONE,
    input wire        o_EXIT_CMD_MODE,
    input wire [15:0] o_UART_DIVISOR,
    input wire [15:0] o_SOURCE_ADDRESS,
    input wire [15:0] o_SILENCE_AFTER_ESCAPE,
    input wire [7:0]  o_RETRY_COUNT,
    input wire [3:0]  o_SLEEP_SELECT,
    input wire [15:0] o_IDLE_BEFORE_SLEEP,
    input wire [15:0] o_UART_RATE_SETTING
);
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_ARST_N);
    property p_excl; !(o_CMD_DONE && o_CMD_ERROR); endproperty
    a_excl: assert property (p_excl) else $error("done with error");
    property p_keep;
        o_CMD_ERROR |-> $stable({o_RETRY_COUNT, o_SLEEP_SELECT, o_IDLE_BEFORE_SLEEP})
            ##1 $stable({o_SILENCE_AFTER_ESCAPE, o_UART_RATE_SETTING});
    endproperty
    a_keep: assert property (p_keep) else $error("setting moved on refusal");
    // divisor only moves on exit, or once out of reset
    property p_div;
        $changed(o_UART_DIVISOR) |-> o_EXIT_CMD_MODE || $past(o_EXIT_CMD_MODE)
            || $past(o_UART_DIVISOR) == 16'h0000;
    endproperty
    a_div: assert property (p_div) else $error("divisor moved early");
    property p_addr; $changed(o_SOURCE_ADDRESS) |-> $past(o_CMD_DONE) or ##[0:2] o_CMD_DONE;
    endproperty
    a_addr: assert property (p_addr) else $error("address moved alone");
    property p_retry; $changed(o_RETRY_COUNT) |-> $past(o_CMD_DONE) or ##[0:2] o_CMD_DONE;
    endproperty
    a_retry: assert property (p_retry) else $error("retry moved alone");
    property p_sleep; o_SLEEP_SELECT != 4'h2 && o_SLEEP_SELECT <= 4'h8; endproperty
    a_sleep: assert property (p_sleep) else $error("sleep select illegal");
    property p_idle; o_IDLE_BEFORE_SLEEP >= 16'h0010; endproperty
    a_idle: assert property (p_idle) else $error("idle time below floor");
    property p_sil; o_SILENCE_AFTER_ESCAPE >= 16'h0002; endproperty
    a_sil: assert property (p_sil) else $error("silence below floor");
    property p_rate; o_UART_RATE_SETTING <= 16'h0006 || o_UART_RATE_SETTING >= 16'h007d;
    endproperty
    a_rate: assert property (p_rate) else $error("rate in gap");
    property p_exit; o_EXIT_CMD_MODE |=> !o_EXIT_CMD_MODE; endproperty
    a_exit: assert property (p_exit) else $error("exit pulse too long");
    c_exit: cover property (o_EXIT_CMD_MODE);
    c_err: cover property (o_CMD_ERROR);
    c_addr: cover property ($changed(o_SOURCE_ADDRESS));
endmodule // scci_checker

bind scci_top scci_checker i_chk (
    .I_SYS_CLK(I_SYS_CLK), .I_ARST_N(I_ARST_N), .o_CMD_ERROR(o_CMD_ERROR),
    .o_CMD_DONE(o_CMD_DONE), .o_EXIT_CMD_MODE(o_EXIT_CMD_MODE),
    .o_UART_DIVISOR(o_UART_DIVISOR), .o_SOURCE_ADDRESS(o_SOURCE_ADDRESS),
    .o_SILENCE_AFTER_ESCAPE(o_SILENCE_AFTER_ESCAPE), .o_RETRY_COUNT(o_RETRY_COUNT),
    .o_SLEEP_SELECT(o_SLEEP_SELECT), .o_IDLE_BEFORE_SLEEP(o_IDLE_BEFORE_SLEEP),
    .o_UART_RATE_SETTING(o_UART_RATE_SETTING));

// ---- tb/scci_host.sv ----
// host controller model: sends text and binary command bytes
// assumes bytes leave one per pulse, launched 1 ns after the edge
`timescale 1ns/10ps
module scci_host (
    input  wire       i_clk,
    output reg        o_valid,
    output reg  [7:0] o_data,
    output reg        o_bin
);
    initial begin
        o_valid = 1'b0;
        o_data = 8'ha5;
        o_bin = 1'b0;
    end
    task send_byte(input [7:0] b);
        begin
            @(posedge i_clk);
            #1 o_valid = 1'b1;
            o_data = b;
            @(posedge i_clk);
            #1 o_valid = 1'b0;
            // released line never shows stale data
            o_data = ~b;
        end
    endtask
    // values go out as hex characters
    task send_text(input [47:0] s, input integer n);
        integer k;
        begin
            for (k = n - 1; k >= 0; k--)
                send_byte(s[8*k+:8]);
        end
    endtask
    // low byte first, select held throughout
    task send_bin(input [7:0] c, input [15:0] v, input h);
        begin
            o_bin = 1'b1;
            send_byte(c);
            if (h) begin
                send_byte(v[7:0]);
                send_byte(v[15:8]);
                repeat (4) @(posedge i_clk);
                #1;
            end
            o_bin = 1'b0;
        end
    endtask
endmodule // scci_host

// ---- tb/tb_serial_config_command_interpreter.sv ----
// self-checking bench of the command interpreter against a behavioural model
// assumes scci_map.vh on the include path; a basic-variant copy shares stimulus
`timescale 1ns/10ps
`include "scci_map.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb_serial_config_command_interpreter;
    reg         clk, arst_n;
    reg  [31:0] serial;
    wire        rx_valid, bin_mode, tx_valid, err, done, ext, stop, err_b;
    wire [7:0]  rx_data, tx_data, esc, retry;
    wire [15:0] div, src, sil_b, sil_a, idle, strm, rate;
    wire [3:0]  sleep;
    integer     fail_count, cmp_count, cycles, i;
    reg  [3:0]  n_done, n_err, n_exit, n_err_b;
    reg  [7:0]  rxq[$];
    reg  [15:0] m_retry, m_stop, m_sleep, m_idle, m_sil, m_stream, m_rate, m_div, m_pend, m_src;
    reg  [15:0] m_sb, m_esc;
    reg  [23:0] tbl[0:17] = '{24'h180100, 24'h360001, 24'h360002, 24'h02000f, 24'h020010,
        24'h050001, 24'h050002, 24'h1a0000, 24'h251111, 24'h141111, 24'h150007,
        24'h15007c, 24'h770001, 24'h040001, 24'h04abcd, 24'h13001f, 24'h130041,
        24'h130080};
    scci_host i_host (.i_clk(clk), .o_valid(rx_valid), .o_data(rx_data), .o_bin(bin_mode));
    // firmware version value is arbitrary
    scci_top #(.FW_VERSION(16'h2468), .ENHANCED(1'b1)) i_dut (.I_SYS_CLK(clk),
        .I_ARST_N(arst_n), .i_RX_VALID(rx_valid), .i_RX_DATA(rx_data), .i_BIN_MODE(bin_mode),
        .i_SERIAL_NUMBER(serial), .o_TX_VALID(tx_valid), .o_TX_DATA(tx_data),
        .o_CMD_ERROR(err), .o_CMD_DONE(done), .o_EXIT_CMD_MODE(ext), .o_UART_DIVISOR(div),
        .o_SOURCE_ADDRESS(src), .o_SILENCE_BEFORE_ESCAPE(sil_b),
        .o_SILENCE_AFTER_ESCAPE(sil_a), .o_ESCAPE_CHARACTER(esc), .o_RETRY_COUNT(retry),
        .o_STOP_BIT_SETTING(stop), .o_SLEEP_SELECT(sleep), .o_IDLE_BEFORE_SLEEP(idle),
        .o_STREAMING_LIMIT(strm), .o_UART_RATE_SETTING(rate));
    scci_top #(.FW_VERSION(16'h2468), .ENHANCED(1'b0)) i_dut_basic (.I_SYS_CLK(clk),
        .I_ARST_N(arst_n), .i_RX_VALID(rx_valid), .i_RX_DATA(rx_data), .i_BIN_MODE(bin_mode),
        .i_SERIAL_NUMBER(serial), .o_TX_VALID(), .o_TX_DATA(), .o_CMD_ERROR(err_b),
        .o_CMD_DONE(), .o_EXIT_CMD_MODE(), .o_UART_DIVISOR(), .o_SOURCE_ADDRESS(),
        .o_SILENCE_BEFORE_ESCAPE(), .o_SILENCE_AFTER_ESCAPE(), .o_ESCAPE_CHARACTER(),
        .o_RETRY_COUNT(), .o_STOP_BIT_SETTING(), .o_SLEEP_SELECT(), .o_IDLE_BEFORE_SLEEP(),
        .o_STREAMING_LIMIT(), .o_UART_RATE_SETTING());
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (done) n_done = n_done + 4'h1;
        if (err) n_err = n_err + 4'h1;
        if (ext) n_exit = n_exit + 4'h1;
        if (err_b) n_err_b = n_err_b + 4'h1;
        if (tx_valid) rxq.push_back(tx_data);
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            print_verdict;
        end
    end
    task print_verdict;
        begin
            $display("compares %0d mismatches %0d", cmp_count, fail_count);
            if (fail_count == 0 && cmp_count > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task clear;
        begin
            n_done = 0;
            n_err = 0;
            n_exit = 0;
            n_err_b = 0;
            rxq = {};
        end
    endtask
    // answer comes within a few cycles; the tail leaves room for the text reply
    task wait_res;
        integer k;
        begin
            for (k = 0; k < 30 && (n_done + n_err) == 0; k++)
                @(posedge clk);
            repeat (10) @(posedge clk);
            #1;
        end
    endtask
    task check_all;
        begin
            `CHK(retry, m_retry[7:0])
            `CHK(stop, m_stop[0])
            `CHK(sleep, m_sleep[3:0])
            `CHK(idle, m_idle)
            `CHK(sil_a, m_sil)
            `CHK(sil_b, m_sb)
            `CHK(esc, m_esc[7:0])
            `CHK(strm, m_stream)
            `CHK(rate, m_rate)
            `CHK(div, m_div)
            `CHK(src, m_src)
        end
    endtask
    task bin_cmd(input [7:0] c, input [15:0] v, input h);
        reg ok;
        begin
            ok = 1'b1;
            clear;
            if (!h) begin
                if (c == `SCCI_B_EXIT_CMD) m_div = m_pend;
                if (c == `SCCI_B_AUTO_ADDR) m_src = {serial[29], serial[28], serial[13:0]};
            end else case (c)
                `SCCI_B_RETRY: if (v > 16'h00ff) ok = 0; else m_retry = v;
                `SCCI_B_STOP_BIT: if (v > 16'h0001) ok = 0; else m_stop = v;
                `SCCI_B_SLEEP_SEL: if (v == 2 || v > 8) ok = 0; else m_sleep = v;
                `SCCI_B_IDLE_SLEEP: if (v < 16'h0010) ok = 0; else m_idle = v;
                `SCCI_B_SILENCE_AFTER: if (v < 16'h0002) ok = 0; else m_sil = v;
                `SCCI_B_SILENCE_BEFORE: if (v < 16'h0002) ok = 0; else m_sb = v;
                `SCCI_B_ESCAPE_CHAR: if (v < 16'h0020 || v > 16'h007f) ok = 0; else m_esc = v;
                `SCCI_B_STREAM_LIM: m_stream = v;
                `SCCI_B_SER_UPPER, `SCCI_B_SER_LOWER, `SCCI_B_FW_VER: ;
                `SCCI_B_UART_RATE: if (v > 6 && v < 16'h007d) ok = 0;
                    else if (v <= 6) begin
                        m_rate = v;
                        m_pend = 16'(1562500 / (v == 6 ? 57600 : 1200 << v));
                    end else begin
                        m_pend = 16'((1562500 + v / 2) / v);
                        m_rate = 16'((1562500 + m_pend / 2) / m_pend);
                    end
                default: ok = 0;
            endcase
            i_host.send_bin(c, v, h);
            wait_res;
            `CHK(n_err, ok ? 4'h0 : 4'h1)
            `CHK(n_done, ok ? 4'h1 : 4'h0)
            check_all;
        end
    endtask
    task txt(input [47:0] s, input integer n, input ok, input [39:0] e, input integer ne);
        begin
            clear;
            i_host.send_text(s, n);
            wait_res;
            `CHK(n_err, ok ? 4'h0 : 4'h1)
            if (ne > 0) `CHK(rxq.size(), ne)
            for (i = 0; i < ne; i++)
                `CHK(rxq[i], e[8*(ne-1-i)+:8])
            check_all;
        end
    endtask
    initial begin
        fail_count = 0;
        cmp_count = 0;
        cycles = 0;
        serial = 32'h0;
        arst_n = 1'b0;
        void'($urandom(32'h0b821c47));
        {m_retry, m_stop, m_sleep, m_idle, m_sil} = {48'h0, 16'h0064, 16'h000a};
        {m_stream, m_rate, m_div, m_pend, m_src} = {16'hffff, 16'h3, 16'd162, 16'd162, 16'hffff};
        {m_sb, m_esc} = {16'h000a, 16'h002b};
        repeat (20) @(posedge clk);
        #1 arst_n = 1'b1;
        repeat (3) @(posedge clk);
        #1 check_all;
        $display("test reset values done");
        bin_cmd(`SCCI_B_RETRY, {8'h00, 8'($urandom)}, 1'b1);
        for (i = 0; i < 18; i++)
            bin_cmd(tbl[i][23:16], tbl[i][15:0], 1'b1);
        for (i = 0; i < 10; i++)
            bin_cmd(`SCCI_B_SLEEP_SEL, 16'(i), 1'b1);
        bin_cmd(`SCCI_B_STREAM_LIM, 16'($urandom), 1'b1);
        $display("test binary writes done");
        bin_cmd(`SCCI_B_UART_RATE, 16'h0005, 1'b1);
        bin_cmd(`SCCI_B_UART_RATE, 16'h0006, 1'b1);
        bin_cmd(`SCCI_B_EXIT_CMD, 16'h0000, 1'b0);
        `CHK(n_exit, 4'h1)
        bin_cmd(`SCCI_B_UART_RATE, 16'h4b00, 1'b1);
        bin_cmd(`SCCI_B_EXIT_CMD, 16'h0000, 1'b0);
        $display("test rate done");
        @(posedge clk);
        #1 serial = $urandom;
        bin_cmd(`SCCI_B_AUTO_ADDR, 16'h0000, 1'b0);
        `CHK(n_err_b, 4'h1)
        $display("test auto address done");
        m_retry = 16'h0037;
        txt(48'h525233370d, 5, 1'b1, 40'h0, 0);
        txt(48'h52520d, 3, 1'b1, 40'h33370d, 3);
        txt(48'h56520d, 3, 1'b1, 40'h323436380d, 5);
        txt(48'h525233470d, 5, 1'b0, 40'h0, 0);
        $display("test text done");
        print_verdict;
    end
endmodule // tb_serial_config_command_interpreter
